// file: tsptc_defines.svh
// Constants of the transport stream packet timing controller
`ifndef TSPTC_DEFINES_SVH
`define TSPTC_DEFINES_SVH
// Packet formats and lengths
`define TSPTC_SYNC_BYTE 8'h47
`define TSPTC_LEN_188 8'hBC
`define TSPTC_LEN_204 8'hCC
`define TSPTC_LEN_208 8'hD0
`define TSPTC_FREE_MIN 8'h10
`define TSPTC_FREE_RST 8'hBC
`define TSPTC_SF_LAST 9'h17F
// Reference counter
`define TSPTC_PCR_LOW_LAST 9'h12B
`define TSPTC_PCR_LOW_MOD 10'h12C
`define TSPTC_REF_MHZ 7'h1B
`define TSPTC_MCLK_MHZ 7'h32
// Restamp window and header fields
`define TSPTC_LINE_LAST 5'h16
`define TSPTC_LINE_FULL 5'h17
`define TSPTC_AFC_BYTE 1
`define TSPTC_HDR_BYTE 3
`define TSPTC_AFL_BYTE 4
`define TSPTC_AFF_BYTE 5
`define TSPTC_PCR_BYTE 6
`define TSPTC_SC1_BYTE 5
`define TSPTC_SC2_BYTE 6
`define TSPTC_PESF_BYTE 11
`define TSPTC_PTS_BYTE 13
`define TSPTC_DTS_BYTE 18
`define TSPTC_PUSI_BIT 6
`define TSPTC_AFC_BIT 5
`define TSPTC_PCRF_BIT 4
`define TSPTC_PTSF_BIT 7
`define TSPTC_DTSF_BIT 6
`define TSPTC_AF_MIN 8'h07
`define TSPTC_SC_ONE 8'h01
// Register byte offsets
`define TSPTC_REG_CTRL 6'h00
`define TSPTC_REG_FREE 6'h04
`define TSPTC_REG_RATE 6'h08
`define TSPTC_REG_STAT 6'h0C
`define TSPTC_REG_TXCNT 6'h10
`define TSPTC_REG_RXCNT 6'h14
`define TSPTC_REG_PCRLO 6'h18
`define TSPTC_REG_PCRHI 6'h1C
`define TSPTC_REG_PCRTOP 6'h20
// Control bits
`define TSPTC_C_RUN 0
`define TSPTC_C_REGEN 1
`define TSPTC_C_SUPER 2
`define TSPTC_C_STAMP 3
`define TSPTC_C_REC 4
`define TSPTC_C_RXSTB 5
`define TSPTC_C_TXCLR 6
`define TSPTC_C_RXCLR 7
`define TSPTC_C_FMT 9:8
`define TSPTC_RATE_RST 16'h0003
`endif

// file: tsptc_pkg.sv
// Types of the transport stream packet timing controller
package tsptc_pkg;
	typedef enum logic [1:0] {
		TSPTC_FMT_188,
		TSPTC_FMT_204,
		TSPTC_FMT_208,
		TSPTC_FMT_FREE
	} tsptc_fmt_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} tsptc_avl_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic byte_en;
		logic byte_valid_strobe;
		logic psync;
	} tsptc_ts_out_t;

	typedef struct packed {
		logic [9:0] ctrl;
		logic [7:0] free_pkt_len;
		logic [7:0] free_data_len;
		logic [15:0] rate;
		logic [15:0] rate_cnt;
		logic tick;
		logic [22:0][7:0] line;
		logic [4:0] fill;
		logic [7:0] in_pos;
		logic [7:0] out_pos;
		logic in_sync;
		logic out_sync;
		logic [8:0] sf_cnt;
		tsptc_ts_out_t ts;
		logic [6:0] ref_acc;
		logic [8:0] pcr_low;
		logic [32:0] pcr_high;
		logic [31:0] tx_cnt;
		logic [23:0] rx_cnt;
		logic [2:0] rxc_sync;
		logic [2:0] rxv_sync;
		logic rxc_lvl;
		logic rxv_lvl;
		logic ack;
		logic [31:0] rdata;
	} tsptc_state_t;
endpackage

// file: tsptc_top.sv
// Transport stream packet timing controller with Avalon-MM registers
// Overview of operation
// - Packets are 188, 204 or 208 bytes, or free length with its own size.
// - Free length takes a packet length and a data length, each held within 16 to 255.
// - In free length only the first data-length bytes of a packet are marked valid.
// - When output starts the valid strobe begins with the first byte of a packet.
// - Outside regeneration and super frame mode the start marker comes with every first byte, whatever its value.
// - In super frame mode the start marker comes once every 384 packets.
// - In regeneration mode the marker is derived from each detected 47h sync byte.
// - Regeneration works only in the 188, 204 and 208 formats, never in free length.
// - The reference counter is a 9-bit low part cycling 0 to 299 and a 33-bit high part.
// - The reference counter advances once per cycle of a 27 MHz rate.
// - In the 188, 204 and 208 formats PCR, PTS and DTS fields are replaced by their original value plus the counter (PTS and DTS: its high part).
// - While recording, a 24-bit counter counts bytes qualified by the receive strobe.
// - Without the strobe the receive counter counts receive clock cycles.
// - A 32-bit counter counts every transmitted byte and software can read it.
`include "tsptc_defines.svh"
module tsptc_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register bus
	input tsptc_pkg::tsptc_avl_req_t avl_req,
	output logic avl_waitrequest,
	output logic [31:0] avl_readdata,
	// Stream from the host buffer
	input wire logic [7:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Parallel stream output
	output tsptc_pkg::tsptc_ts_out_t ts_out,
	// Receive pins
	input wire logic rx_clk_pin,
	input wire logic rx_valid_pin
);
	tsptc_pkg::tsptc_state_t st_ff;
	tsptc_pkg::tsptc_state_t nxt_st;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] clamp_len(input logic [7:0] v);
		return (v < `TSPTC_FREE_MIN) ? `TSPTC_FREE_MIN : v;
	endfunction

	function automatic logic [7:0] pkt_len(input tsptc_pkg::tsptc_fmt_t f,
		input logic [7:0] free_len);
		logic [7:0] r;
		case (f)
			tsptc_pkg::TSPTC_FMT_188: r = `TSPTC_LEN_188;
			tsptc_pkg::TSPTC_FMT_204: r = `TSPTC_LEN_204;
			tsptc_pkg::TSPTC_FMT_208: r = `TSPTC_LEN_208;
			default: r = free_len;
		endcase
		return r;
	endfunction

	// Adds the counter to a 33-bit timestamp with markers kept
	function automatic logic [39:0] ts_add(input logic [39:0] f, input logic [32:0] add);
		logic [32:0] s;
		s = {f[35:33], f[31:17], f[15:1]} + add;
		return {f[39:36], s[32:30], f[32], s[29:15], f[16], s[14:0], f[0]};
	endfunction

	// Adds base and extension of the counter to a clock reference
	function automatic logic [47:0] pcr_add(input logic [47:0] f, input logic [32:0] hi,
		input logic [8:0] lo);
		logic [9:0] e;
		logic [32:0] b;
		e = {1'b0, f[8:0]} + {1'b0, lo};
		b = f[47:15] + hi;
		if (e >= `TSPTC_PCR_LOW_MOD) begin
			e = e - `TSPTC_PCR_LOW_MOD;
			b = b + 33'h0_0000_0001;
		end
		return {b, f[14:9], e[8:0]};
	endfunction

	tsptc_pkg::tsptc_fmt_t fmt;
	logic [7:0] plen;
	logic [7:0] dlen;
	logic fixed_fmt;
	logic regen;
	logic shift;
	logic emit;
	logic [22:0][7:0] nl;
	logic [7:0] ob;
	logic [7:0] opos;
	logic osync;
	logic det;
	logic [6:0] acc_sum;
	logic rxc_rise;
	logic [5:0] addr;
	logic wr_now;
	logic [31:0] bm;

	assign fmt = tsptc_pkg::tsptc_fmt_t'(st_ff.ctrl[`TSPTC_C_FMT]);
	assign plen = pkt_len(fmt, st_ff.free_pkt_len);
	assign fixed_fmt = (fmt != tsptc_pkg::TSPTC_FMT_FREE);
	assign regen = st_ff.ctrl[`TSPTC_C_REGEN] & fixed_fmt;
	assign in_ready = st_ff.ctrl[`TSPTC_C_RUN] & st_ff.tick;
	assign shift = in_ready & in_valid;
	assign emit = shift & (st_ff.fill == `TSPTC_LINE_FULL);
	assign avl_waitrequest = (avl_req.read | avl_req.write) & ~st_ff.ack;
	assign avl_readdata = st_ff.rdata;
	assign ts_out = st_ff.ts;
	assign addr = {avl_req.address[5:2], 2'b00};
	assign wr_now = avl_req.write & st_ff.ack;

	always_comb begin
		nxt_st = st_ff;
		bm = 32'h0000_0000;
		// Effective data length of a packet
		if (fixed_fmt) begin
			dlen = plen;
		end else begin
			dlen = (st_ff.free_data_len < plen) ? st_ff.free_data_len : plen;
		end
		// Byte slot divider
		nxt_st.tick = 1'b0;
		if (st_ff.rate_cnt == 16'h0000) begin
			nxt_st.rate_cnt = st_ff.rate;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.rate_cnt = st_ff.rate_cnt - 16'h0001;
		end
		// Input side: shift line and restamp a complete header
		nl = {st_ff.line[21:0], in_data};
		if (shift) begin
			if (regen && in_data == `TSPTC_SYNC_BYTE && (!st_ff.in_sync || st_ff.in_pos == 8'h00)) begin
				nxt_st.in_sync = 1'b1;
				nxt_st.in_pos = 8'h01;
			end else if (st_ff.in_pos == plen - 8'h01) begin
				nxt_st.in_pos = 8'h00;
			end else begin
				nxt_st.in_pos = st_ff.in_pos + 8'h01;
			end
			if (st_ff.ctrl[`TSPTC_C_STAMP] && fixed_fmt && (st_ff.in_sync || !regen)
				&& st_ff.in_pos == {3'b000, `TSPTC_LINE_LAST}
				&& nl[`TSPTC_LINE_LAST] == `TSPTC_SYNC_BYTE) begin
				if (nl[`TSPTC_LINE_LAST - `TSPTC_HDR_BYTE][`TSPTC_AFC_BIT]
					&& nl[`TSPTC_LINE_LAST - `TSPTC_AFL_BYTE] >= `TSPTC_AF_MIN
					&& nl[`TSPTC_LINE_LAST - `TSPTC_AFF_BYTE][`TSPTC_PCRF_BIT]) begin
					nl[`TSPTC_LINE_LAST - `TSPTC_PCR_BYTE -: 6] = pcr_add(
						nl[`TSPTC_LINE_LAST - `TSPTC_PCR_BYTE -: 6],
						st_ff.pcr_high, st_ff.pcr_low);
				end
				if (nl[`TSPTC_LINE_LAST - `TSPTC_AFC_BYTE][`TSPTC_PUSI_BIT]
					&& !nl[`TSPTC_LINE_LAST - `TSPTC_HDR_BYTE][`TSPTC_AFC_BIT]
					&& nl[`TSPTC_LINE_LAST - `TSPTC_AFL_BYTE] == 8'h00
					&& nl[`TSPTC_LINE_LAST - `TSPTC_SC1_BYTE] == 8'h00
					&& nl[`TSPTC_LINE_LAST - `TSPTC_SC2_BYTE] == `TSPTC_SC_ONE
					&& nl[`TSPTC_LINE_LAST - `TSPTC_PESF_BYTE][`TSPTC_PTSF_BIT]) begin
					nl[`TSPTC_LINE_LAST - `TSPTC_PTS_BYTE -: 5] = ts_add(
						nl[`TSPTC_LINE_LAST - `TSPTC_PTS_BYTE -: 5], st_ff.pcr_high);
					if (nl[`TSPTC_LINE_LAST - `TSPTC_PESF_BYTE][`TSPTC_DTSF_BIT]) begin
						nl[`TSPTC_LINE_LAST - `TSPTC_DTS_BYTE -: 5] = ts_add(
							nl[`TSPTC_LINE_LAST - `TSPTC_DTS_BYTE -: 5], st_ff.pcr_high);
					end
				end
			end
			nxt_st.line = nl;
			if (st_ff.fill != `TSPTC_LINE_FULL) begin
				nxt_st.fill = st_ff.fill + 5'h01;
			end
		end
		// Output side: marker and valid strobe
		ob = st_ff.line[`TSPTC_LINE_LAST];
		det = regen && ob == `TSPTC_SYNC_BYTE && (!st_ff.out_sync || st_ff.out_pos == 8'h00);
		opos = det ? 8'h00 : st_ff.out_pos;
		osync = regen ? (st_ff.out_sync | det) : 1'b1;
		nxt_st.ts.byte_en = in_ready;
		nxt_st.ts.byte_valid_strobe = 1'b0;
		nxt_st.ts.psync = 1'b0;
		if (emit) begin
			nxt_st.ts.data = ob;
			nxt_st.out_sync = osync;
			nxt_st.ts.byte_valid_strobe = osync && (opos < dlen);
			if (opos == 8'h00 && osync && (!regen || det)) begin
				nxt_st.ts.psync = !st_ff.ctrl[`TSPTC_C_SUPER] || st_ff.sf_cnt == 9'h000;
				nxt_st.sf_cnt = (st_ff.sf_cnt == `TSPTC_SF_LAST) ? 9'h000 : st_ff.sf_cnt + 9'h001;
			end
			if (osync) begin
				nxt_st.out_pos = (opos == plen - 8'h01) ? 8'h00 : opos + 8'h01;
			end
		end
		// Stopped output restarts aligned to a packet start
		if (!st_ff.ctrl[`TSPTC_C_RUN]) begin
			nxt_st.fill = 5'h00;
			nxt_st.in_pos = 8'h00;
			nxt_st.out_pos = 8'h00;
			nxt_st.in_sync = 1'b0;
			nxt_st.out_sync = 1'b0;
			nxt_st.sf_cnt = 9'h000;
		end
		// Reference counter on a fractional 27 MHz enable
		acc_sum = st_ff.ref_acc + `TSPTC_REF_MHZ;
		if (acc_sum >= `TSPTC_MCLK_MHZ) begin
			nxt_st.ref_acc = acc_sum - `TSPTC_MCLK_MHZ;
			if (st_ff.pcr_low == `TSPTC_PCR_LOW_LAST) begin
				nxt_st.pcr_low = 9'h000;
				nxt_st.pcr_high = st_ff.pcr_high + 33'h0_0000_0001;
			end else begin
				nxt_st.pcr_low = st_ff.pcr_low + 9'h001;
			end
		end else begin
			nxt_st.ref_acc = acc_sum;
		end
		// Receive pins through three stages
		nxt_st.rxc_sync = {st_ff.rxc_sync[1:0], rx_clk_pin};
		nxt_st.rxv_sync = {st_ff.rxv_sync[1:0], rx_valid_pin};
		if (st_ff.rxc_sync[1] == st_ff.rxc_sync[2]) begin
			nxt_st.rxc_lvl = st_ff.rxc_sync[2];
		end
		if (st_ff.rxv_sync[1] == st_ff.rxv_sync[2]) begin
			nxt_st.rxv_lvl = st_ff.rxv_sync[2];
		end
		rxc_rise = nxt_st.rxc_lvl & ~st_ff.rxc_lvl;
		// Transmit and receive counters, a count in the cycle of a clear starts from zero
		if (wr_now && addr == `TSPTC_REG_CTRL && avl_req.byteenable[0]) begin
			if (avl_req.writedata[`TSPTC_C_TXCLR]) begin
				nxt_st.tx_cnt = 32'h0000_0000;
			end
			if (avl_req.writedata[`TSPTC_C_RXCLR]) begin
				nxt_st.rx_cnt = 24'h00_0000;
			end
		end
		if (emit) begin
			nxt_st.tx_cnt = nxt_st.tx_cnt + 32'h0000_0001;
		end
		if (st_ff.ctrl[`TSPTC_C_REC] && rxc_rise) begin
			if (!st_ff.ctrl[`TSPTC_C_RXSTB]) begin
				nxt_st.rx_cnt = nxt_st.rx_cnt + 24'h00_0001;
			end else if (st_ff.rxv_lvl) begin
				nxt_st.rx_cnt = nxt_st.rx_cnt + 24'h00_0001;
			end
		end
		// Register bus, one wait cycle per access
		nxt_st.ack = (avl_req.read | avl_req.write) & ~st_ff.ack;
		if (avl_req.read && !st_ff.ack) begin
			case (addr)
				`TSPTC_REG_CTRL: nxt_st.rdata = {22'h00_0000, st_ff.ctrl[9:8], 2'b00, st_ff.ctrl[5:0]};
				`TSPTC_REG_FREE: nxt_st.rdata = {16'h0000, st_ff.free_data_len, st_ff.free_pkt_len};
				`TSPTC_REG_RATE: nxt_st.rdata = {16'h0000, st_ff.rate};
				`TSPTC_REG_STAT: nxt_st.rdata = {28'h000_0000, st_ff.fill == `TSPTC_LINE_FULL,
					st_ff.in_sync, st_ff.out_sync, st_ff.ctrl[`TSPTC_C_RUN]};
				`TSPTC_REG_TXCNT: nxt_st.rdata = st_ff.tx_cnt;
				`TSPTC_REG_RXCNT: nxt_st.rdata = {8'h00, st_ff.rx_cnt};
				`TSPTC_REG_PCRLO: nxt_st.rdata = {23'h00_0000, st_ff.pcr_low};
				`TSPTC_REG_PCRHI: nxt_st.rdata = st_ff.pcr_high[31:0];
				`TSPTC_REG_PCRTOP: nxt_st.rdata = {31'h0000_0000, st_ff.pcr_high[32]};
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_now) begin
			case (addr)
				`TSPTC_REG_CTRL: begin
					bm = be_merge({22'h00_0000, st_ff.ctrl}, avl_req.writedata,
						avl_req.byteenable);
					nxt_st.ctrl = bm[9:0];
					nxt_st.ctrl[`TSPTC_C_TXCLR] = 1'b0;
					nxt_st.ctrl[`TSPTC_C_RXCLR] = 1'b0;
				end
				`TSPTC_REG_FREE: begin
					if (avl_req.byteenable[0]) begin
						nxt_st.free_pkt_len = clamp_len(avl_req.writedata[7:0]);
					end
					if (avl_req.byteenable[1]) begin
						nxt_st.free_data_len = clamp_len(avl_req.writedata[15:8]);
					end
				end
				`TSPTC_REG_RATE: begin
					bm = be_merge({16'h0000, st_ff.rate}, avl_req.writedata,
						avl_req.byteenable);
					nxt_st.rate = bm[15:0];
				end
				default: nxt_st.ack = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.free_pkt_len <= `TSPTC_FREE_RST;
			st_ff.free_data_len <= `TSPTC_FREE_RST;
			st_ff.rate <= `TSPTC_RATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

// file: tsptc_properties.sv
// Port checker of the packet timing controller, bound to its top
`include "tsptc_defines.svh"
module tsptc_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register bus
	input tsptc_pkg::tsptc_avl_req_t avl_req,
	input wire logic avl_waitrequest,
	input wire logic [31:0] avl_readdata,
	// Stream
	input wire logic [7:0] in_data,
	input wire logic in_valid,
	input wire logic in_ready,
	input tsptc_pkg::tsptc_ts_out_t ts_out,
	// Receive pins
	input wire logic rx_clk_pin,
	input wire logic rx_valid_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic req;
	logic rd_done;
	assign req = avl_req.read | avl_req.write;
	assign rd_done = avl_req.read & ~avl_waitrequest;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_wait_first: assert property ($rose(req) |-> avl_waitrequest)
		else $error("no wait state at request start");
	a_wait_one: assert property (req && avl_waitrequest |=> !avl_waitrequest)
		else $error("request not answered after one wait state");
	a_slot_follow: assert property (in_ready |=> ts_out.byte_en)
		else $error("byte slot missing after ready");
	a_slot_cause: assert property (ts_out.byte_en |-> $past(in_ready))
		else $error("byte slot without ready");
	a_psync_slot: assert property (ts_out.psync |-> ts_out.byte_en)
		else $error("start marker outside a byte slot");
	a_valid_slot: assert property (ts_out.byte_valid_strobe |-> ts_out.byte_en)
		else $error("valid strobe outside a byte slot");
	a_data_hold: assert property (!ts_out.byte_en |-> $stable(ts_out.data))
		else $error("output byte changed between slots");
	a_free_floor: assert property (rd_done && avl_req.address == `TSPTC_REG_FREE
		|-> avl_readdata[7:0] >= 8'h10 && avl_readdata[15:8] >= 8'h10)
		else $error("free length below sixteen");
	a_pcr_range: assert property (rd_done && avl_req.address == `TSPTC_REG_PCRLO
		|-> avl_readdata <= 32'h0000_012B)
		else $error("low reference count above 299");
	a_rx_width: assert property (rd_done && avl_req.address == `TSPTC_REG_RXCNT
		|-> avl_readdata[31:24] == 8'h00)
		else $error("receive counter wider than 24 bits");
endmodule
bind tsptc_top tsptc_properties chk_u (.mclk(mclk), .rstn(rstn), .avl_req(avl_req),
	.avl_waitrequest(avl_waitrequest), .avl_readdata(avl_readdata), .in_data(in_data),
	.in_valid(in_valid), .in_ready(in_ready), .ts_out(ts_out),
	.rx_clk_pin(rx_clk_pin), .rx_valid_pin(rx_valid_pin));

// file: tsptc_far_end.sv
// Far-end receive source driving the receive pins
module tsptc_far_end #(
	parameter int N_EDGES = 20
) (
	// Bench control
	input wire logic go,
	// Receive pins
	output logic rx_clk_pin,
	output logic rx_valid_pin,
	// Status
	output logic [7:0] n_valid,
	output logic done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pat = 8'hA5;
	initial begin
		rx_clk_pin = 1'b0;
		rx_valid_pin = 1'b0;
		n_valid = 8'h00;
		done = 1'b0;
	end
	// Burst of clock edges, valid changed only while the clock is low
	always @(posedge go) begin
		done = 1'b0;
		n_valid = 8'h00;
		for (int k = 0; k < N_EDGES; k++) begin
			pat = {pat[6:0], pat[7] ^ pat[5]};
			rx_valid_pin = pat[0];
			#110 rx_clk_pin = 1'b1;
			n_valid = n_valid + {7'h00, pat[0]};
			#110 rx_clk_pin = 1'b0;
		end
		// Clock stands still, valid shows no stale level
		rx_valid_pin = ~rx_valid_pin;
		done = 1'b1;
	end
endmodule

// file: tb_top.sv
// Self-checking bench of the packet timing controller
`include "tsptc_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	tsptc_pkg::tsptc_avl_req_t avl_req = '0;
	logic avl_waitrequest;
	logic [31:0] avl_readdata;
	logic [7:0] in_data = 8'h00;
	logic in_valid = 1'b0;
	logic in_ready;
	tsptc_pkg::tsptc_ts_out_t ts_out;
	logic rx_clk_pin;
	logic rx_valid_pin;
	logic go = 1'b0;
	logic [7:0] n_valid;
	logic done;
	logic [15:0] lfsr_q = 16'h51C6;
	int lens[3] = '{`TSPTC_LEN_188, `TSPTC_LEN_204, `TSPTC_LEN_208};
	int fails = 0;
	int n_tests = 0;
	int tx_seen = 0;
	logic [31:0] rd_q[$];
	logic [10:0] exp_q[$];
	logic [10:0] hist[$];
	always #10 mclk = ~mclk;
	tsptc_top dut_u (.mclk(mclk), .rstn(rstn), .avl_req(avl_req),
		.avl_waitrequest(avl_waitrequest), .avl_readdata(avl_readdata), .in_data(in_data),
		.in_valid(in_valid), .in_ready(in_ready), .ts_out(ts_out),
		.rx_clk_pin(rx_clk_pin), .rx_valid_pin(rx_valid_pin));
	tsptc_far_end far_u (.go(go), .rx_clk_pin(rx_clk_pin), .rx_valid_pin(rx_valid_pin),
		.n_valid(n_valid), .done(done));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic print_verdict();
		if (fails == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected register value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_byte(input logic [10:0] e);
		logic [9:0] g;
		logic [9:0] x;
		g = {ts_out.psync, ts_out.byte_valid_strobe & e[10], ts_out.data};
		x = {e[9], e[8] & e[10], e[7:0]};
		n_tests++;
		if (g !== x) begin
			fails++;
			$display("unexpected stream byte at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic avl_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
		logic w;
		@(posedge mclk);
		avl_req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
		do begin
			@(negedge mclk);
			w = avl_waitrequest;
			@(posedge mclk);
		end while (w);
		avl_req <= '0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		avl_xfer(1'b0, a, 32'h0000_0000);
	endtask
	// Feeds n bytes; packet 1 starts with a broken sync byte
	task automatic stream(input logic [9:0] ctl, input int plen, input int dlen, input int n);
		logic [7:0] b;
		logic fix;
		logic rdy;
		int pos;
		fix = ctl[9:8] != 2'h3;
		avl_xfer(1'b1, `TSPTC_REG_CTRL, {22'h0, ctl});
		for (int i = 0; i < n; i++) begin
			pos = i % plen;
			lfsr_q = lfsr(lfsr_q);
			b = (pos != 0) ? lfsr_q[7:0] : ((i == plen) ? 8'h00 : `TSPTC_SYNC_BYTE);
			if (b == `TSPTC_SYNC_BYTE && pos != 0) b = 8'h48;
			in_data <= b;
			in_valid <= 1'b1;
			hist.push_back({!(ctl[1] && fix), pos == 0 && (!(ctl[1] && fix)
				|| b == `TSPTC_SYNC_BYTE) && (!ctl[2] || (i / plen) % 384 == 0), pos < dlen, b});
			do begin
				@(negedge mclk);
				rdy = in_ready;
				@(posedge mclk);
			end while (!rdy);
			if (hist.size() > 23) begin
				exp_q.push_back(hist.pop_front());
				tx_seen++;
			end
		end
		in_valid <= 1'b0;
		hist.delete();
		avl_xfer(1'b1, `TSPTC_REG_CTRL, 32'h0000_0000);
	endtask
	task automatic rx_burst();
		@(posedge mclk);
		go <= 1'b1;
		do @(posedge mclk); while (!done);
		go <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
	// Result watcher
	always @(negedge mclk) begin
		if (avl_req.read && !avl_waitrequest && rd_q.size() > 0)
			chk_reg(rd_q.pop_front(), avl_readdata);
		if (ts_out.byte_en && exp_q.size() > 0) chk_byte(exp_q.pop_front());
	end
	initial begin
		repeat (40000) @(posedge mclk);
		fails++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		rd(`TSPTC_REG_CTRL, 32'h0000_0000);
		rd(`TSPTC_REG_FREE, 32'h0000_BCBC);
		rd(`TSPTC_REG_RATE, 32'h0000_0003);
		rd(6'h24, 32'h0000_0000);
		avl_xfer(1'b1, `TSPTC_REG_FREE, 32'h0000_0508);
		rd(`TSPTC_REG_FREE, 32'h0000_1010);
		avl_xfer(1'b1, `TSPTC_REG_RATE, 32'h0000_0000);
		avl_xfer(1'b1, `TSPTC_REG_CTRL, 32'h0000_0040);
		tx_seen = 0;
		for (int f = 0; f < 3; f++) stream({f[1:0], 8'h01}, lens[f], lens[f], 2 * lens[f] + 23);
		stream(10'h003, 188, 188, 3 * 188 + 23);
		avl_xfer(1'b1, `TSPTC_REG_FREE, 32'h0000_1114);
		stream(10'h303, 20, 17, 3 * 20 + 23);
		avl_xfer(1'b1, `TSPTC_REG_FREE, 32'h0000_1010);
		stream(10'h305, 16, 16, 385 * 16 + 23);
		rd(`TSPTC_REG_TXCNT, 32'(tx_seen));
		chk_reg(32'h0000_0000, 32'(exp_q.size()));
		avl_xfer(1'b0, `TSPTC_REG_PCRLO, 32'h0000_0000);
		avl_xfer(1'b1, `TSPTC_REG_CTRL, 32'h0000_0090);
		rx_burst();
		rd(`TSPTC_REG_RXCNT, 32'h0000_0014);
		avl_xfer(1'b1, `TSPTC_REG_CTRL, 32'h0000_00B0);
		rx_burst();
		rd(`TSPTC_REG_RXCNT, {24'h00_0000, n_valid});
		print_verdict();
	end
endmodule
